// ### common/adc_clk_cfg_pkg.sv
package adc_clk_cfg_pkg;

  // ----------------------------------------------------------------
  // sizes and register map
  // ----------------------------------------------------------------
  localparam int          NUM_CHAN        = 4;
  localparam int          ADDR_W          = 12;
  localparam int          CHAN_LANE_W     = 8;
  localparam logic [11:0] ADDR_CLOCK_CTRL = 12'h000;
  localparam logic [11:0] ADDR_CHAN_CFG   = 12'h004;
  localparam logic [11:0] ADDR_STATUS     = 12'h008;
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;

  // ----------------------------------------------------------------
  // modes and field layouts
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PWR_HIGH_RESOLUTION,
    PWR_LOW_POWER,
    PWR_VERY_LOW_POWER,
    PWR_RESERVED
  } power_mode_t;

  typedef enum logic [1:0] {
    SEL_INPUT_PINS,
    SEL_ANALOG_GROUND,
    SEL_TEST_POS,
    SEL_TEST_NEG
  } input_sel_t;

  // clock control word, bit 0 upward: source select, power mode, standby
  typedef struct packed {
    logic        standby;
    power_mode_t pwr;
    logic        clkSel;
  } clk_ctrl_t;

  // one byte lane per channel: input select in [1:0], gain code in [4:2]
  typedef struct packed {
    logic [2:0] gain;
    input_sel_t sel;
  } chan_cfg_t;

  localparam clk_ctrl_t CLK_CTRL_RST = '{standby: 1'h0, pwr: PWR_HIGH_RESOLUTION, clkSel: 1'h0};
  localparam chan_cfg_t CHAN_CFG_RST = '{gain: 3'h0, sel: SEL_INPUT_PINS};
  localparam int        STAT_REF_READY_BIT = 0;
  localparam int        STAT_OSC_ON_BIT    = 1;
  localparam int        STAT_CONV_BIT      = 2;

  // ----------------------------------------------------------------
  // analog scaling in microvolts
  // ----------------------------------------------------------------
  localparam logic [20:0] FSR_BASE_UV  = 21'h124F80;
  localparam int          TEST_NUM     = 2;
  localparam int          TEST_DEN     = 15;
  localparam logic [18:0] TEST_BASE_UV = 19'(int'(FSR_BASE_UV) * TEST_NUM / TEST_DEN);

  // ----------------------------------------------------------------
  // clocking
  // ----------------------------------------------------------------
  localparam longint      REF_CLK_HZ     = 100000000;
  localparam int          REF_CLK_MHZ    = 100;
  localparam longint      OSC_HZ         = 8192000;
  localparam logic [31:0] NCO_INC        = 32'((64'(OSC_HZ) << 32) / 64'(REF_CLK_HZ));
  localparam logic [1:0]  DIV_LOG2_X1    = 2'h0;
  localparam logic [1:0]  DIV_LOG2_X2    = 2'h1;
  localparam logic [1:0]  DIV_LOG2_X4    = 2'h2;
  localparam logic [1:0]  MOD_DIV_LOG2   = 2'h1;
  localparam int          REF_SETTLE_US  = 100;

endpackage

// ### hdl/tick_divider.sv
`timescale 1ns/1ns
// ------------------------------------------------------------------
// divides a stream of enable pulses by 1, 2 or 4
// ------------------------------------------------------------------
module tick_divider
  import adc_clk_cfg_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       rstn,
  input  wire logic       clear,
  input  wire logic       tickIn,
  input  wire logic [1:0] log2Ratio,
  output logic            tickOut
);

  logic [1:0] cnt_q;
  logic [1:0] mask;
  logic       wrap;

  // mask of the count; >= catches a ratio lowered mid-count
  assign mask = 2'((3'h1 << log2Ratio) - 3'h1);
  assign wrap = tickIn && (cnt_q >= mask);

  // phase restart on clear keeps the output free of short periods
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q   <= 2'h0;
      tickOut <= 1'h0;
    end else begin
      tickOut <= wrap && !clear;
      if (clear || wrap) begin
        cnt_q <= 2'h0;
      end else if (tickIn) begin
        cnt_q <= cnt_q + 2'h1;
      end
    end
  end

endmodule

// ### hdl/adc_clock_and_channel_config.sv
// Chosen here: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ns
// ------------------------------------------------------------------
// ------------------------------------------------------------------
module adc_clock_and_channel_config
  import adc_clk_cfg_pkg::*;
#(
  parameter int REF_SETTLE_CYC = REF_SETTLE_US * REF_CLK_MHZ
)
(
  input  wire logic                              ref_clk,
  input  wire logic                              rstn,
  input  wire logic [ADDR_W-1:0]                 awaddr,
  input  wire logic                              awvalid,
  output logic                                   awready,
  input  wire logic [31:0]                       wdata,
  input  wire logic [3:0]                        wstrb,
  input  wire logic                              wvalid,
  output logic                                   wready,
  output logic [1:0]                             bresp,
  output logic                                   bvalid,
  input  wire logic                              bready,
  input  wire logic [ADDR_W-1:0]                 araddr,
  input  wire logic                              arvalid,
  output logic                                   arready,
  output logic [31:0]                            rdata,
  output logic [1:0]                             rresp,
  output logic                                   rvalid,
  input  wire logic                              rready,
  input  wire logic                              extClkIn,
  output logic                                   oscEnable,
  output logic                                   mclkTick,
  output logic                                   modTick,
  output logic                                   convEnable,
  output chan_cfg_t [NUM_CHAN-1:0]               chanCfg,
  output logic      [NUM_CHAN-1:0][20:0]         fsrUv,
  output logic      [NUM_CHAN-1:0][18:0]         testLevelUv
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [20:0] fsr_of(input logic [2:0] gain);
    fsr_of = FSR_BASE_UV >> gain;
  endfunction

  function automatic logic [18:0] test_of(input chan_cfg_t cfg);
    logic [18:0] mag;
    mag = TEST_BASE_UV >> cfg.gain;
    case (cfg.sel)
      SEL_TEST_POS: test_of = mag;
      SEL_TEST_NEG: test_of = 19'(-mag);
      default:      test_of = 19'h0;
    endcase
  endfunction

  function automatic logic [1:0] div_of(input power_mode_t pwr);
    case (pwr)
      PWR_HIGH_RESOLUTION: div_of = DIV_LOG2_X1;
      PWR_LOW_POWER:       div_of = DIV_LOG2_X2;
      default:             div_of = DIV_LOG2_X4;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // register state and bus slave
  // ----------------------------------------------------------------
  clk_ctrl_t                ctrl_q;
  chan_cfg_t [NUM_CHAN-1:0] cfg_q;
  logic [ADDR_W-1:0]        awAddr_q;
  logic [31:0]              wData_q;
  logic [3:0]               wStrb_q;
  logic                     awHeld_q;
  logic                     wHeld_q;
  logic                     awReady_q;
  logic                     wReady_q;
  logic                     bValid_q;
  logic [1:0]               bResp_q;
  logic                     arReady_q;
  logic                     rValid_q;
  logic [31:0]              rData_q;
  logic [1:0]               rResp_q;
  logic                     refReady_q;
  logic                     doWrite;
  logic                     wrCtrl;
  logic                     wrChan;
  logic                     wrKnown;
  logic                     rdKnown;
  logic [31:0]              rdMux;
  logic [31:0]              statusWord;
  power_mode_t              pwrWr;

  // write fires once both halves are held; reserved power code folds to very low power
  assign doWrite = awHeld_q && wHeld_q && !bValid_q;
  assign wrCtrl  = doWrite && (awAddr_q[ADDR_W-1:2] == ADDR_CLOCK_CTRL[ADDR_W-1:2]);
  assign wrChan  = doWrite && (awAddr_q[ADDR_W-1:2] == ADDR_CHAN_CFG[ADDR_W-1:2]);
  assign wrKnown = wrCtrl || wrChan || (awAddr_q[ADDR_W-1:2] == ADDR_STATUS[ADDR_W-1:2]);
  assign pwrWr   = (wData_q[2:1] == 2'h3) ? PWR_VERY_LOW_POWER : power_mode_t'(wData_q[2:1]);

  // read decode, unused bits read zero
  assign statusWord = {29'h0, convEnable, oscEnable, refReady_q};
  assign rdKnown    = (araddr[ADDR_W-1:2] == ADDR_CLOCK_CTRL[ADDR_W-1:2]) ||
                      (araddr[ADDR_W-1:2] == ADDR_CHAN_CFG[ADDR_W-1:2]) ||
                      (araddr[ADDR_W-1:2] == ADDR_STATUS[ADDR_W-1:2]);
  assign rdMux = (araddr[ADDR_W-1:2] == ADDR_CLOCK_CTRL[ADDR_W-1:2]) ? {28'h0, ctrl_q} :
                 (araddr[ADDR_W-1:2] == ADDR_CHAN_CFG[ADDR_W-1:2])   ?
                   {3'h0, cfg_q[3], 3'h0, cfg_q[2], 3'h0, cfg_q[1], 3'h0, cfg_q[0]} :
                 (araddr[ADDR_W-1:2] == ADDR_STATUS[ADDR_W-1:2])     ? statusWord : 32'h0;

  // write address channel
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      awHeld_q  <= 1'h0;
      awReady_q <= 1'h1;
      awAddr_q  <= '0;
    end else if (awvalid && awReady_q) begin
      awHeld_q  <= 1'h1;
      awReady_q <= 1'h0;
      awAddr_q  <= awaddr;
    end else if (doWrite) begin
      awHeld_q  <= 1'h0;
    end else if (bValid_q && bready) begin
      awReady_q <= 1'h1;
    end
  end

  // write data channel, either order against the address
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      wHeld_q  <= 1'h0;
      wReady_q <= 1'h1;
      wData_q  <= 32'h0;
      wStrb_q  <= 4'h0;
    end else if (wvalid && wReady_q) begin
      wHeld_q  <= 1'h1;
      wReady_q <= 1'h0;
      wData_q  <= wdata;
      wStrb_q  <= wstrb;
    end else if (doWrite) begin
      wHeld_q  <= 1'h0;
    end else if (bValid_q && bready) begin
      wReady_q <= 1'h1;
    end
  end

  // write response; status is read-only and silently keeps its value
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      bValid_q <= 1'h0;
      bResp_q  <= RESP_OKAY;
    end else if (doWrite) begin
      bValid_q <= 1'h1;
      bResp_q  <= wrKnown ? RESP_OKAY : RESP_SLVERR;
    end else if (bValid_q && bready) begin
      bValid_q <= 1'h0;
    end
  end

  // clock control register, low byte lane only
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_q <= CLK_CTRL_RST;
    end else if (wrCtrl && wStrb_q[0]) begin
      ctrl_q <= '{standby: wData_q[3], pwr: pwrWr, clkSel: wData_q[0]};
    end
  end

  // per-channel config, one byte lane each so channels update independently
  for (genvar ch = 0; ch < NUM_CHAN; ch++) begin : g_chan
    always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
        cfg_q[ch] <= CHAN_CFG_RST;
      end else if (wrChan && wStrb_q[ch]) begin
        cfg_q[ch] <= chan_cfg_t'(wData_q[ch*CHAN_LANE_W +: 5]);
      end
    end
  end

  // read channel, answer on the same edge that takes the address
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      arReady_q <= 1'h1;
      rValid_q  <= 1'h0;
      rData_q   <= 32'h0;
      rResp_q   <= RESP_OKAY;
    end else if (arvalid && arReady_q) begin
      arReady_q <= 1'h0;
      rValid_q  <= 1'h1;
      rData_q   <= rdMux;
      rResp_q   <= rdKnown ? RESP_OKAY : RESP_SLVERR;
    end else if (rValid_q && rready) begin
      arReady_q <= 1'h1;
      rValid_q  <= 1'h0;
    end
  end

  assign awready = awReady_q;
  assign wready  = wReady_q;
  assign bvalid  = bValid_q;
  assign bresp   = bResp_q;
  assign arready = arReady_q;
  assign rvalid  = rValid_q;
  assign rdata   = rData_q;
  assign rresp   = rResp_q;

  // ----------------------------------------------------------------
  // clock sources
  // ----------------------------------------------------------------
  logic        extSync1_q;
  logic        extSync2_q;
  logic        extPrev_q;
  logic        extEdge;
  logic [31:0] ncoAcc_q;
  logic [32:0] ncoSum;
  logic        oscTick_q;
  logic        intTick;
  logic        mainSrc;

  // pin crosses in two flops; edge taken only behind the second
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      extSync1_q <= 1'h0;
      extSync2_q <= 1'h0;
      extPrev_q  <= 1'h0;
    end else begin
      extSync1_q <= extClkIn;
      extSync2_q <= extSync1_q;
      extPrev_q  <= extSync2_q;
    end
  end
  assign extEdge = extSync2_q && !extPrev_q;

  // oscillator modelled as a phase accumulator; jitter is one ref cycle
  assign ncoSum = {1'h0, ncoAcc_q} + {1'h0, NCO_INC};
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      oscEnable <= 1'h0;
      ncoAcc_q  <= 32'h0;
      oscTick_q <= 1'h0;
    end else begin
      oscEnable <= ctrl_q.clkSel;
      ncoAcc_q  <= oscEnable ? ncoSum[31:0] : 32'h0;
      oscTick_q <= oscEnable && ncoSum[32];
    end
  end

  // no sequencer: the host must quiesce via standby before changing these
  tick_divider u_osc_div (
    .ref_clk   (ref_clk),
    .rstn      (rstn),
    .clear     (!oscEnable),
    .tickIn    (oscTick_q),
    .log2Ratio (div_of(ctrl_q.pwr)),
    .tickOut   (intTick)
  );

  // source mux; external edges rely on a continuous clock from outside
  assign mainSrc = ctrl_q.clkSel ? intTick : extEdge;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      mclkTick <= 1'h0;
    end else begin
      mclkTick <= mainSrc;
    end
  end

  tick_divider u_mod_div (
    .ref_clk   (ref_clk),
    .rstn      (rstn),
    .clear     (1'h0),
    .tickIn    (mclkTick),
    .log2Ratio (MOD_DIV_LOG2),
    .tickOut   (modTick)
  );

  // ----------------------------------------------------------------
  // reference settling and channel outputs
  // ----------------------------------------------------------------
  logic [31:0] settleCnt_q;

  // conversions held off until the reference settle time has run out
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      settleCnt_q <= 32'h0;
      refReady_q  <= 1'h0;
      convEnable  <= 1'h0;
    end else begin
      if (!refReady_q) begin
        settleCnt_q <= settleCnt_q + 32'h1;
      end
      refReady_q <= refReady_q || (settleCnt_q >= 32'(REF_SETTLE_CYC - 1));
      convEnable <= refReady_q && !ctrl_q.standby;
    end
  end

  // scaling per channel, registered so outputs leave from flops
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      chanCfg     <= {NUM_CHAN{CHAN_CFG_RST}};
      fsrUv       <= {NUM_CHAN{FSR_BASE_UV}};
      testLevelUv <= '0;
    end else begin
      for (int ch = 0; ch < NUM_CHAN; ch++) begin
        chanCfg[ch]     <= cfg_q[ch];
        fsrUv[ch]       <= fsr_of(cfg_q[ch].gain);
        testLevelUv[ch] <= test_of(cfg_q[ch]);
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  logic [2:0] oscSince_q;
  logic       divClean_q;

  // osc ticks since the last main tick; unclean after any control write
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      oscSince_q <= 3'h0;
      divClean_q <= 1'h0;
    end else begin
      oscSince_q <= mclkTick ? 3'h0 : oscSince_q + {2'h0, oscTick_q};
      divClean_q <= !wrCtrl && (divClean_q || mclkTick);
    end
  end

  property p_ext_source;
    !ctrl_q.clkSel && extEdge |=> mclkTick;
  endproperty
  a_ext_source: assert property (p_ext_source) else $error("external edge missed on main clock");

  property p_reset_source;
    $rose(rstn) |-> !ctrl_q.clkSel && !oscEnable;
  endproperty
  a_reset_source: assert property (@(posedge ref_clk) p_reset_source) else $error("wrong source after reset");

  property p_osc_off;
    !ctrl_q.clkSel [*3] |-> !oscTick_q && !intTick;
  endproperty
  a_osc_off: assert property (p_osc_off) else $error("oscillator runs while deselected");

  property p_pwr_legal;
    ctrl_q.pwr != PWR_RESERVED;
  endproperty
  a_pwr_legal: assert property (p_pwr_legal) else $error("reserved power mode stored");

  property p_osc_div;
    ctrl_q.clkSel && mclkTick && divClean_q |-> oscSince_q == 3'h1 << div_of(ctrl_q.pwr);
  endproperty
  a_osc_div: assert property (p_osc_div) else $error("oscillator divide ratio wrong");

  property p_mod_half;
    modTick |-> $past(mclkTick) && !mclkTick;
  endproperty
  a_mod_half: assert property (p_mod_half) else $error("modulator tick not from main tick");

  property p_ref_gate;
    !refReady_q |-> !convEnable ##1 (refReady_q || !convEnable);
  endproperty
  a_ref_gate: assert property (p_ref_gate) else $error("conversion before reference settled");

  property p_settle_time;
    $rose(refReady_q) |-> settleCnt_q == 32'(REF_SETTLE_CYC);
  endproperty
  a_settle_time: assert property (p_settle_time) else $error("reference settle time wrong");

  for (genvar ch = 0; ch < NUM_CHAN; ch++) begin : g_chk
    property p_fsr_scale;
      $stable(cfg_q[ch]) [*2] |-> (24'(fsrUv[ch]) << chanCfg[ch].gain) == 24'(FSR_BASE_UV);
    endproperty
    a_fsr_scale: assert property (p_fsr_scale) else $error("full-scale range off gain");

    property p_test_frac;
      $stable(cfg_q[ch]) [*2] ##0 chanCfg[ch].sel == SEL_TEST_NEG
        |-> 24'(19'(-testLevelUv[ch])) * 24'(TEST_DEN) == 24'(fsrUv[ch]) * 24'(TEST_NUM);
    endproperty
    a_test_frac: assert property (p_test_frac) else $error("test level not two fifteenths");

    property p_lane_alone;
      wrChan && !wStrb_q[ch] |=> $stable(cfg_q[ch]);
    endproperty
    a_lane_alone: assert property (p_lane_alone) else $error("channel changed without its lane");
  end

endmodule

// ### sim/ext_clk_src.sv
`timescale 1ns/1ns
// ----------------------------------------
// external clock source
// ----------------------------------------
module ext_clk_src #(
  parameter int HALF_NS = 50
)
(
  input  wire logic run,
  output logic      extClk
);
  // free running while run is high, parked low otherwise
  // single process owns the pin, so it starts low and never has two drivers
  always begin
    extClk = 1'b0;
    forever begin
      #(HALF_NS);
      extClk = run ? ~extClk : 1'b0;
    end
  end
endmodule

// ### sim/tb_adc_clock_and_channel_config.sv
`timescale 1ns/1ns
module tb_adc_clock_and_channel_config
  import adc_clk_cfg_pkg::*;
();
  logic ref_clk, rstn, awvalid, wvalid, bready, arvalid, rready, extRun, extClk;
  logic awready, wready, bvalid, arready, rvalid, oscEnable, mclkTick, modTick, convEnable;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, w, d;
  logic [3:0]  wstrb, s;
  logic [1:0]  bresp, rresp, r;
  chan_cfg_t [NUM_CHAN-1:0]       chanCfg;
  logic [NUM_CHAN-1:0][20:0]      fsrUv;
  logic [NUM_CHAN-1:0][18:0]      testLevelUv;
  logic [4:0]  cfgM [NUM_CHAN];
  int n_mismatch, checks, m, k, t;

  adc_clock_and_channel_config #(.REF_SETTLE_CYC(20)) dut_u (.ref_clk(ref_clk), .rstn(rstn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .extClkIn(extClk), .oscEnable(oscEnable),
    .mclkTick(mclkTick), .modTick(modTick), .convEnable(convEnable), .chanCfg(chanCfg),
    .fsrUv(fsrUv), .testLevelUv(testLevelUv));
  ext_clk_src #(.HALF_NS(50)) ext_u (.run(extRun), .extClk(extClk));

  always #5 ref_clk = ~ref_clk;

  // ----------------------------------------
  // checking and bus tasks
  // ----------------------------------------
  task automatic finish_test();
    $display("mismatches %0d of %0d checks", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  // tick counts drift with synchroniser phase, so allow a tolerance
  task automatic near(input int got, input int exp, input int tol, input string msg);
    checks++;
    if (got < exp - tol || got > exp + tol) begin
      n_mismatch++;
      $display("wrong value at %0t: %s got %0d exp %0d", $time, msg, got, exp);
    end
  endtask

  task automatic axi_wr(input logic [11:0] a, input logic [31:0] dv, input logic [3:0] sv,
                        output logic [1:0] rv);
    int n;
    @(posedge ref_clk);
    awaddr <= a; awvalid <= 1'b1; wdata <= dv; wstrb <= sv; wvalid <= 1'b1; bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge ref_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        rv = bresp;
        bready <= 1'b0;
        break;
      end
    end
    if (n == 50) begin n_mismatch++; finish_test(); end
  endtask

  task automatic axi_rd(input logic [11:0] a, output logic [31:0] dv, output logic [1:0] rv);
    int n;
    @(posedge ref_clk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge ref_clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        dv = rdata; rv = rresp;
        rready <= 1'b0;
        break;
      end
    end
    if (n == 50) begin n_mismatch++; finish_test(); end
  endtask

  task automatic count_ticks(input int cyc, output int mc, output int md);
    mc = 0; md = 0;
    repeat (cyc) begin
      @(posedge ref_clk);
      if (mclkTick === 1'b1) mc++;
      if (modTick === 1'b1) md++;
    end
  endtask

  function automatic logic [18:0] exp_test(input logic [4:0] c);
    logic [18:0] v;
    v = 19'(32'd160000 >> c[4:2]);
    return (c[1:0] == 2'h2) ? v : (c[1:0] == 2'h3) ? 19'(-v) : 19'h0;
  endfunction

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    ref_clk = 0; rstn = 0; awvalid = 0; wvalid = 0; bready = 0; arvalid = 0; rready = 0;
    awaddr = 0; araddr = 0; wdata = 0; wstrb = 0; extRun = 1; n_mismatch = 0; checks = 0;
    void'($urandom(32'h7bcdec28));
    repeat (10) @(posedge ref_clk);
    rstn <= 1'b1;
    // settle count from release, then conversion allowed
    for (t = 0; t < 100 && convEnable !== 1'b1; t++) @(posedge ref_clk);
    // enable rises settle+1 edges after release and is seen one edge later
    near(t, 22, 0, "settle");
    axi_rd(ADDR_CLOCK_CTRL, d, r);
    chk(d, 32'h0, "ctrl reset");
    chk(32'(oscEnable), 32'h0, "osc off");
    count_ticks(4000, m, k);
    near(m, 400, 4, "ext mclk");
    near(k, m / 2, 2, "ext mod");
    axi_rd(12'h00C, d, r);
    chk({d[31:2], r}, {30'h0, RESP_SLVERR}, "unmapped rd");
    axi_wr(12'h010, 32'hFFFFFFFF, 4'hF, r);
    chk(32'(r), 32'(RESP_SLVERR), "unmapped wr");
    // status is read-only: the write is answered OKAY and changes nothing
    axi_wr(ADDR_STATUS, 32'h0, 4'hF, r);
    chk(32'(r), 32'(RESP_OKAY), "status wr");
    axi_rd(ADDR_STATUS, d, r);
    chk(d[2:0], 3'h5, "status");
    // channel setup: one fixed corner word, the rest random
    for (int c = 0; c < NUM_CHAN; c++) cfgM[c] = 5'h0;
    for (int i = 0; i < 10; i++) begin
      w = (i == 0) ? 32'h1F170B04 : $urandom;
      s = (i == 0) ? 4'hF : 4'($urandom);
      axi_wr(ADDR_CHAN_CFG, w, s, r);
      for (int c = 0; c < NUM_CHAN; c++) if (s[c]) cfgM[c] = w[8*c +: 5];
      repeat (3) @(posedge ref_clk);
      for (int c = 0; c < NUM_CHAN; c++) begin
        chk(32'(chanCfg[c]), 32'(cfgM[c]), "chan cfg");
        chk(32'(fsrUv[c]), 32'(FSR_BASE_UV >> cfgM[c][4:2]), "fsr");
        chk(32'(testLevelUv[c]), 32'(exp_test(cfgM[c])), "test level");
      end
      axi_rd(ADDR_CHAN_CFG, d, r);
      chk(d, {3'h0, cfgM[3], 3'h0, cfgM[2], 3'h0, cfgM[1], 3'h0, cfgM[0]}, "cfg rd");
    end
    // internal oscillator in every power code, code 3 reads back as 2
    for (int p = 0; p < 4; p++) begin
      // standby first with the running setting, only then change source or mode
      axi_wr(ADDR_CLOCK_CTRL, 32'(p == 0 ? 8 : 7 + 2 * p), 4'h1, r);
      axi_wr(ADDR_CLOCK_CTRL, 32'(9 + 2 * p), 4'h1, r);
      repeat (2) @(posedge ref_clk);
      chk(32'(convEnable), 32'h0, "standby");
      axi_wr(ADDR_CLOCK_CTRL, 32'(1 + 2 * p), 4'h1, r);
      axi_rd(ADDR_CLOCK_CTRL, d, r);
      chk(d, 32'(1 + 2 * (p > 2 ? 2 : p)), "ctrl rd");
      repeat (100) @(posedge ref_clk);
      chk(32'(oscEnable), 32'h1, "osc on");
      count_ticks(4000, m, k);
      near(m, 327 >> (p > 2 ? 2 : p), 3, "osc mclk");
      near(k, m / 2, 2, "osc mod");
    end
    chk(32'(convEnable), 32'h1, "conv back");
    // back to the external pin, again under standby
    axi_wr(ADDR_CLOCK_CTRL, 32'hD, 4'h1, r);
    axi_wr(ADDR_CLOCK_CTRL, 32'h8, 4'h1, r);
    axi_wr(ADDR_CLOCK_CTRL, 32'h0, 4'h1, r);
    repeat (20) @(posedge ref_clk);
    chk(32'(oscEnable), 32'h0, "osc off again");
    count_ticks(4000, m, k);
    near(m, 400, 4, "ext mclk again");
    finish_test();
  end

  // hang guard
  initial begin
    #900000;
    n_mismatch++;
    finish_test();
  end
endmodule
